/* pkg/pefc_params.svh */
`ifndef PEFC_PARAMS_SVH
`define PEFC_PARAMS_SVH

// Maintenance packet format type and the hop count that ends at this device.
`define PEFC_FTYPE_MAINT        4'h8
`define PEFC_HOP_LOCAL          8'h00

// Maintenance transaction codes.
`define PEFC_TTYPE_READ         4'h0
`define PEFC_TTYPE_WRITE        4'h1

// Register offset (byte address) and composite reset value.
`define PEFC_FEAT_OFFSET        24'h000010
`define PEFC_FEAT_RESET         32'h1000051f

// Field positions, counted from the most significant bit as bit 0.
`define PEFC_POS_BRIDGE         0
`define PEFC_POS_ENDPOINT       1
`define PEFC_POS_PROCESSOR      2
`define PEFC_POS_SWITCH         3
`define PEFC_POS_MULTICAST      21
`define PEFC_POS_BRINGUP        23
`define PEFC_POS_LARGE_ID       27
`define PEFC_POS_EXT_VALID      28
`define PEFC_POS_EXT_ADDR       29

// Field values.
`define PEFC_VAL_BRIDGE         1'h0
`define PEFC_VAL_ENDPOINT       1'h0
`define PEFC_VAL_PROCESSOR      1'h0
`define PEFC_VAL_SWITCH         1'h1
`define PEFC_VAL_MULTICAST      1'h1
`define PEFC_VAL_BRINGUP        1'h1
`define PEFC_VAL_LARGE_ID       1'h1
`define PEFC_VAL_EXT_VALID      1'h1
`define PEFC_VAL_EXT_ADDR       3'h7

`endif

/* pkg/pefc_pkg.sv */
`include "pefc_params.svh"

package pefc_pkg;

	typedef enum logic [1:0] {
		PEFC_RSP_DONE,
		PEFC_RSP_ERROR
	} pefc_status_t;

	typedef logic [31:0] pefc_word_t;

endpackage : pefc_pkg

/* rtl/pefc_features_capability.sv */
`timescale 1ns/100ps
// Overview of operation
// [RULE1] The capability register sits at offset 0x10, is read-only and always reads 0x1000_051F.
// [RULE2] Bit 0 reads zero because the device cannot bridge to another interface type.
// [RULE3] Bit 1 reads zero because the device has no space reachable by non-maintenance reads or writes.
// [RULE4] Bit 2 reads zero because the device holds no code-executing processor.
// [RULE5] Bit 3 reads one, and maintenance packets with hop count zero go to the register bus, not onward.
// [RULE6] Bit 21 reads one to advertise the multicast extensions.
// [RULE7] Bit 23 reads one to advertise the system bring-up register extension.
// [RULE8] Forwarding follows the ingress lookup table and bit 27 steers nothing.
// [RULE9] Bit 27 reads one, meaning both 8-bit and 16-bit destination IDs are supported.
// [RULE10] Bit 28 reads one, marking the extended-features pointer as valid.
// [RULE11] Bits 29 to 31 read 0b111 for 66-, 50- and 34-bit extended addressing.
// [RULE12] Reserved bits read zero and writes to the register change nothing.

`include "pefc_params.svh"

module pefc_features_capability (
	input  wire logic                  core_clk,
	input  wire logic                  nrst,
	input  wire logic                  pktValid,
	output logic                       pktReady,
	input  wire logic [3:0]            pktFtype,
	input  wire logic [7:0]            pktHopCount,
	input  wire logic [3:0]            pktTtype,
	input  wire logic [23:0]           pktOffset,
	input  wire logic [31:0]           pktWrData,
	output logic                       fwdValid,
	input  wire logic                  fwdReady,
	output logic                       rspValid,
	output pefc_pkg::pefc_word_t       rspData,
	output pefc_pkg::pefc_status_t     rspStatus
);
	import pefc_pkg::*;

	// ************************************************
	// Field assembly
	// ************************************************

	// Converts a most-significant-first bit number into a vector index.
	function automatic int unsigned pefc_idx(input int unsigned pos);
		return 31 - pos;
	endfunction : pefc_idx

	pefc_word_t featValue;
	pefc_word_t fieldMask;
	pefc_word_t featWord;

	// Returns the word with one bit, numbered most-significant-first, set to the value.
	function automatic pefc_word_t pefc_put_bit(
		input pefc_word_t  word,
		input int unsigned pos,
		input logic        val
	);
		pefc_word_t result;
		result = word;
		result[pefc_idx(pos)] = val;
		return result;
	endfunction : pefc_put_bit

	// ************************************************
	// Named fields
	// ************************************************

	// Each field is tied to the value that this device reports about itself.
	logic       bridgeCapable;
	logic       endpointCapable;
	logic       processorPresent;
	logic       switchCapable;
	logic       multicastSupported;
	logic       bringupExtensionSupported;
	logic       largeDestinationIdSupported;
	logic       extendedFeaturesValid;
	logic [2:0] extendedAddressingSupport;

	assign bridgeCapable               = `PEFC_VAL_BRIDGE;     // RULE2
	assign endpointCapable             = `PEFC_VAL_ENDPOINT;   // RULE3
	assign processorPresent            = `PEFC_VAL_PROCESSOR;  // RULE4
	assign switchCapable               = `PEFC_VAL_SWITCH;     // RULE5
	assign multicastSupported          = `PEFC_VAL_MULTICAST;  // RULE6
	assign bringupExtensionSupported   = `PEFC_VAL_BRINGUP;    // RULE7
	assign largeDestinationIdSupported = `PEFC_VAL_LARGE_ID;   // RULE9
	assign extendedFeaturesValid       = `PEFC_VAL_EXT_VALID;  // RULE10
	assign extendedAddressingSupport   = `PEFC_VAL_EXT_ADDR;   // RULE11

	// ************************************************
	// Word assembly
	// ************************************************

	always_comb begin
		featValue = '0;                                                                  // RULE12
		featValue = pefc_put_bit(featValue, `PEFC_POS_BRIDGE, bridgeCapable);            // RULE2
		featValue = pefc_put_bit(featValue, `PEFC_POS_ENDPOINT, endpointCapable);        // RULE3
		featValue = pefc_put_bit(featValue, `PEFC_POS_PROCESSOR, processorPresent);      // RULE4
		featValue = pefc_put_bit(featValue, `PEFC_POS_SWITCH, switchCapable);            // RULE5
		featValue = pefc_put_bit(featValue, `PEFC_POS_MULTICAST, multicastSupported);    // RULE6
		featValue = pefc_put_bit(featValue, `PEFC_POS_BRINGUP, bringupExtensionSupported); // RULE7
		featValue = pefc_put_bit(featValue, `PEFC_POS_LARGE_ID, largeDestinationIdSupported); // RULE9
		featValue = pefc_put_bit(featValue, `PEFC_POS_EXT_VALID, extendedFeaturesValid); // RULE10
		featValue[pefc_idx(`PEFC_POS_EXT_ADDR) -: 3] = extendedAddressingSupport;        // RULE11
	end

	// Only documented fields may reach the bus; every reserved position stays zero.
	always_comb begin
		fieldMask = '0;
		fieldMask = pefc_put_bit(fieldMask, `PEFC_POS_BRIDGE, 1'b1);
		fieldMask = pefc_put_bit(fieldMask, `PEFC_POS_ENDPOINT, 1'b1);
		fieldMask = pefc_put_bit(fieldMask, `PEFC_POS_PROCESSOR, 1'b1);
		fieldMask = pefc_put_bit(fieldMask, `PEFC_POS_SWITCH, 1'b1);
		fieldMask = pefc_put_bit(fieldMask, `PEFC_POS_MULTICAST, 1'b1);
		fieldMask = pefc_put_bit(fieldMask, `PEFC_POS_BRINGUP, 1'b1);
		fieldMask = pefc_put_bit(fieldMask, `PEFC_POS_LARGE_ID, 1'b1);
		fieldMask = pefc_put_bit(fieldMask, `PEFC_POS_EXT_VALID, 1'b1);
		fieldMask[pefc_idx(`PEFC_POS_EXT_ADDR) -: 3] = 3'h7;
	end

	assign featWord = featValue & fieldMask;                                             // RULE12

	// ************************************************
	// Packet steering
	// ************************************************

	// True for a maintenance packet whose hop count has run out at this device.
	function automatic logic pefc_is_local(
		input logic [3:0] ftype,
		input logic [7:0] hops
	);
		return (ftype == `PEFC_FTYPE_MAINT) && (hops == `PEFC_HOP_LOCAL);
	endfunction : pefc_is_local

	logic isLocal;
	logic taken;

	// The routing decision looks only at type and hop count, never at the capability bits.
	assign isLocal  = pefc_is_local(pktFtype, pktHopCount);                              // RULE5
	assign fwdValid = pktValid && !isLocal;                                              // RULE8
	// Local packets are always accepted; everything else waits on the routing path.
	assign pktReady = isLocal ? 1'b1 : fwdReady;                                         // RULE5
	assign taken    = pktValid && isLocal;                                               // RULE5

	// ************************************************
	// Offset decode
	// ************************************************

	// Compares the word address of a request with the register's offset; byte lanes are ignored.
	function automatic logic pefc_offset_hit(
		input logic [23:0] offset
	);
		return offset[23:2] == 22'(`PEFC_FEAT_OFFSET >> 2);
	endfunction : pefc_offset_hit

	logic offsetMatch;

	assign offsetMatch = pefc_offset_hit(pktOffset);                                     // RULE1

	// ************************************************
	// Transaction decode
	// ************************************************

	// True when the transaction code of the request equals the given code.
	function automatic logic pefc_ttype_is(
		input logic [3:0] ttype,
		input logic [3:0] code
	);
		return ttype == code;
	endfunction : pefc_ttype_is

	logic isRead;
	logic isWrite;
	logic readHit;
	logic writeHit;

	assign isRead   = pefc_ttype_is(pktTtype, `PEFC_TTYPE_READ);
	assign isWrite  = pefc_ttype_is(pktTtype, `PEFC_TTYPE_WRITE);
	assign readHit  = offsetMatch && isRead;                                             // RULE1
	assign writeHit = offsetMatch && isWrite;                                            // RULE12

	// ************************************************
	// Register bus answer
	// ************************************************

	pefc_word_t   next_rspData;
	pefc_status_t next_rspStatus;

	// Anything but a read or write of this register is answered with an error and no data.
	always_comb begin
		next_rspData   = '0;
		next_rspStatus = PEFC_RSP_ERROR;
		if (readHit) begin
			next_rspData   = featWord;                                                   // RULE1
			next_rspStatus = PEFC_RSP_DONE;
		end else if (writeHit) begin
			// Write data is dropped; the register keeps its fixed value.
			next_rspStatus = PEFC_RSP_DONE;                                              // RULE12
		end
	end

	// Exactly one answer follows every taken local packet, one cycle later.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rspValid <= 1'b0;
		end else begin
			rspValid <= taken;                                                           // RULE5
		end
	end

	// Data and status hold until the next local packet is taken.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rspData <= '0;
		end else if (taken) begin
			rspData <= next_rspData;                                                     // RULE1
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rspStatus <= PEFC_RSP_DONE;
		end else if (taken) begin
			rspStatus <= next_rspStatus;
		end
	end

endmodule : pefc_features_capability

/* verif/pefc_route_sink.sv */
`timescale 1ns/100ps
module pefc_route_sink (
	input  wire logic nrst,
	input  wire logic stall,
	output logic      fwdReady
);
	assign fwdReady = nrst && !stall;
endmodule : pefc_route_sink

/* verif/pefc_features_capability_assertions.sv */
`timescale 1ns/100ps
module pefc_features_capability_assertions (
	input wire logic core_clk, nrst, pktValid, pktReady, fwdValid, fwdReady, rspValid,
	input wire logic [3:0] pktFtype, pktTtype,
	input wire logic [7:0] pktHopCount,
	input wire logic [23:0] pktOffset,
	input pefc_pkg::pefc_word_t rspData,
	input pefc_pkg::pefc_status_t rspStatus
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire loc = pktFtype == 4'h8 && pktHopCount == 8'h00;
	wire hit = pktOffset[23:2] == 22'h4;
	sequence s_take; pktValid && loc; endsequence
	sequence s_rd; pktValid && loc && hit && pktTtype == 4'h0; endsequence
	sequence s_wr; pktValid && loc && hit && pktTtype == 4'h1; endsequence
	a_local_answer: assert property (s_take |=> rspValid) else $error("no answer");
	a_no_spurious: assert property (!(pktValid && loc) |=> !rspValid) else $error("extra");
	a_local_kept: assert property (s_take |-> pktReady && !fwdValid) else $error("kept");
	a_fwd_pass: assert property (pktValid && !loc |-> fwdValid && pktReady == fwdReady) else $error("fwd");
	a_read_value: assert property (s_rd |=> rspData == 32'h1000051f && rspStatus == 2'h0) else $error("rd");
	a_write_ignored: assert property (s_wr ##1 s_rd |=> rspData == 32'h1000051f) else $error("wr");
	a_other_error: assert property (pktValid && loc && !(hit && pktTtype < 4'h2) |=> rspStatus == 2'h1
		&& rspData == 32'h0) else $error("err");
	a_rsp_hold: assert property (!rspValid |-> $stable(rspData) && $stable(rspStatus)) else $error("hold");
endmodule : pefc_features_capability_assertions
bind pefc_features_capability pefc_features_capability_assertions pefc_features_capability_assertions_inst (
	.core_clk    (core_clk),
	.nrst        (nrst),
	.pktValid    (pktValid),
	.pktReady    (pktReady),
	.fwdValid    (fwdValid),
	.fwdReady    (fwdReady),
	.rspValid    (rspValid),
	.pktFtype    (pktFtype),
	.pktTtype    (pktTtype),
	.pktHopCount (pktHopCount),
	.pktOffset   (pktOffset),
	.rspData     (rspData),
	.rspStatus   (rspStatus)
);

/* verif/pefc_features_capability_tb.sv */
`timescale 1ns/100ps
module pefc_features_capability_tb;
	import pefc_pkg::*;
	logic core_clk, nrst, pktValid, stall, pktReady, fwdValid, fwdReady, rspValid, loc, expV;
	logic [3:0] pktFtype, pktTtype;
	logic [7:0] pktHopCount;
	logic [23:0] pktOffset;
	logic [31:0] pktWrData, seed, r;
	logic [33:0] want;
	pefc_word_t rspData;
	pefc_status_t rspStatus;
	int err_total, samples_checked;
	pefc_features_capability pefc_features_capability_inst (
		.core_clk    (core_clk),
		.nrst        (nrst),
		.pktValid    (pktValid),
		.pktReady    (pktReady),
		.pktFtype    (pktFtype),
		.pktHopCount (pktHopCount),
		.pktTtype    (pktTtype),
		.pktOffset   (pktOffset),
		.pktWrData   (pktWrData),
		.fwdValid    (fwdValid),
		.fwdReady    (fwdReady),
		.rspValid    (rspValid),
		.rspData     (rspData),
		.rspStatus   (rspStatus)
	);
	pefc_route_sink pefc_route_sink_inst (
		.nrst     (nrst),
		.stall    (stall),
		.fwdReady (fwdReady)
	);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Status in the top two bits, register word below.
	function automatic logic [33:0] want_rsp(logic [3:0] tt, logic [23:0] off);
		if (off[23:2] == 22'h4 && tt == 4'h0)
			return {2'h0, 32'h7 | 32'h1 << 3 | 32'h1 << 4 | 32'h1 << 8 | 32'h1 << 10 | 32'h1 << 28};
		return {(off[23:2] == 22'h4 && tt == 4'h1) ? 2'h0 : 2'h1, 32'h0};
	endfunction : want_rsp
	task automatic cmp(logic [33:0] got, logic [33:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask : cmp
	task automatic end_of_test();
		if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		#20000 err_total++;
		end_of_test();
	end
	initial begin
		{seed, nrst, pktValid, stall, pktFtype, pktTtype, pktHopCount, pktOffset, pktWrData} = 0;
		{expV, want} = 0;
		seed = 32'h15863;
		repeat (5) @(negedge core_clk);
		nrst = 1;
		for (int i = 0; i < 600; i++) begin
			@(negedge core_clk);
			cmp({33'h0, rspValid}, {33'h0, expV});
			if (expV) cmp({rspStatus, rspData}, want);
			r = rnd();
			pktValid = r[0] || i < 4;
			pktFtype = r[1] || i < 4 ? 4'h8 : r[7:4];
			pktHopCount = r[2] || i < 4 ? 8'h00 : r[15:8];
			pktOffset = i == 3 ? 24'h14 : r[3] || i < 4 ? {22'h4, r[21:20]} : r[31:8];
			pktTtype = i < 4 ? {3'h0, i == 1} : {2'h0, r[23:22]};
			stall = r[18];
			pktWrData = rnd();
			#1 loc = pktFtype == 4'h8 && pktHopCount == 8'h00;
			cmp({32'h0, fwdValid, pktReady}, {32'h0, pktValid && !loc, loc || !stall});
			expV = pktValid && loc;
			want = want_rsp(pktTtype, pktOffset);
		end
		end_of_test();
	end
endmodule : pefc_features_capability_tb
